// ---- verilog/panel_bus_params.svh ----
// Timing and field constants for the panel bus master
`ifndef PANEL_BUS_PARAMS_SVH
`define PANEL_BUS_PARAMS_SVH
`define CLK_PERIOD_NS        5
`define STORE_LOW_TIME_NS    170
`define STORE_HIGH_TIME_NS   85
`define STORE_CYCLE_TIME_NS  255
`define FETCH_LOW_TIME_NS    300
`define FETCH_HIGH_TIME_NS   300
`define FETCH_CYCLE_TIME_NS  600
`define PANEL_RESET_TIME_NS  10000
`define MASTER_RESET_TIME_NS 2000
`define DATA_W               8
`define CNT_W                16
`define CNT_ONE              16'h0001
`define CNT_ZERO             16'h0000
`define BYTE_ZERO            8'h00
`define OP_RD_INDEX          2'h0
`define OP_WR_INDEX          2'h1
`define OP_RD_DATA           2'h2
`define OP_WR_DATA           2'h3
`define OP_WRITE_BIT         0
`define OP_DATA_BIT          1
`endif

// ---- verilog/panel_bus_pkg.sv ----
// Types shared by the panel bus master
package panel_bus_pkg;
    typedef logic [1:0] op_t;
    typedef enum logic [5:0] {
        ST_RESET = 6'b000001,
        ST_IDLE  = 6'b000010,
        ST_SETUP = 6'b000100,
        ST_LOW   = 6'b001000,
        ST_HIGH  = 6'b010000,
        ST_DONE  = 6'b100000
    } phase_t;
endpackage

// ---- verilog/phase_timer.sv ----
// Down-counter that flags expiry of a loaded cycle count
`timescale 1ns/10ps
`include "panel_bus_params.svh"
module phase_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] count_i,
    output logic                  expired_o
);
    logic [CNT_W-1:0] remain;

    initial begin
        if (CNT_W < 4) begin
            $error("phase_timer: CNT_W too small");
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            remain <= '0;
        end else if (load_i) begin
            remain <= count_i;
        end else if (remain != '0) begin
            remain <= remain - CNT_W'(1);
        end
    end

    // Expiry depends on the count only, so a load decided from it is no loop
    assign expired_o = (remain == '0);

endmodule // phase_timer

// ---- verilog/panel_bus_master.sv ----
// 8-bit 80-series parallel bus master for a display panel
// Functional notes
// - Status read: select low, index_or_data_select low, write high, read pulses.
// - Index write: select low, index_or_data_select low, read high, write pulses.
// - Memory read: select low, index_or_data_select high, write high, read pulses.
// - Data write: select low, index_or_data_select high, read high, write pulses.
// - Accesses happen only while select is low; select high means nothing.
// - All transfers use one shared 8-bit two-way panel_data_bus.
// - Panel is initialised by a low pulse on its reset output.
// - Write strobe low while write data are presented on the bus.
// - Read strobe low while the panel returns data on the bus.
// - Write strobe low at least 170 ns, high at least 85 ns.
// - Read strobe low at least 300 ns, high at least 300 ns.
// - Master reset is an external low pulse over 2 us only; arst_n_i resets at once on any low level, its width unchecked.
`timescale 1ns/10ps
`include "panel_bus_params.svh"
module panel_bus_master
    import panel_bus_pkg::*;
#(
    parameter int PANEL_RESET_NS = `PANEL_RESET_TIME_NS
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 req_valid_i,
    output logic                      req_ready_o,
    input  wire panel_bus_pkg::op_t   req_op_i,
    input  wire logic [`DATA_W-1:0]   req_data_i,
    output logic                      rsp_valid_o,
    output logic [`DATA_W-1:0]        rsp_data_o,
    output logic                      panel_select_n_o,
    output logic                      index_or_data_select_o,
    output logic                      fetch_strobe_n_o,
    output logic                      store_strobe_n_o,
    output logic                      panel_reset_n_o,
    input  wire logic [`DATA_W-1:0]   panel_data_bus_i,
    output logic [`DATA_W-1:0]        panel_data_bus_o,
    output logic                      panel_data_bus_oe_o
);
    import panel_bus_pkg::*;

    localparam int CLK_NS = `CLK_PERIOD_NS;
    // Least times round up to whole cycles
    localparam int STORE_LOW_CYC =
        (`STORE_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int STORE_HIGH_CYC =
        (`STORE_HIGH_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int FETCH_LOW_CYC =
        (`FETCH_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int FETCH_HIGH_CYC =
        (`FETCH_HIGH_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int PANEL_RESET_CYC =
        (PANEL_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int STORE_CYCLE_CYC =
        (`STORE_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int FETCH_CYCLE_CYC =
        (`FETCH_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;

    initial begin
        if (PANEL_RESET_CYC < 2 || PANEL_RESET_CYC > 65535) begin
            $error("panel_bus_master: PANEL_RESET_NS out of range");
        end
        if (STORE_LOW_CYC + STORE_HIGH_CYC < STORE_CYCLE_CYC ||
            FETCH_LOW_CYC + FETCH_HIGH_CYC < FETCH_CYCLE_CYC) begin
            $error("panel_bus_master: cycle total not met");
        end
    end

    phase_t           phase;
    op_t              op;
    logic             expired;
    logic             load;
    logic [`CNT_W-1:0] load_count;

    // Timer load counts are one less for the low phase, since load takes a cycle, and two less for the high phase
    always_comb begin
        load       = 1'b0;
        load_count = `CNT_ZERO;
        case (phase)
            ST_RESET: begin
                load       = 1'b0;
                load_count = `CNT_ZERO;
            end
            ST_IDLE: begin
                load       = req_valid_i;
                load_count = `CNT_ONE;
            end
            ST_SETUP: begin
                load       = expired;
                load_count = op[`OP_WRITE_BIT]
                    ? `CNT_W'(STORE_LOW_CYC - 1)
                    : `CNT_W'(FETCH_LOW_CYC - 1);
            end
            ST_LOW: begin
                load       = expired;
                load_count = op[`OP_WRITE_BIT]
                    ? `CNT_W'(STORE_HIGH_CYC - 2)
                    : `CNT_W'(FETCH_HIGH_CYC - 2);
            end
            default: begin
                load       = 1'b0;
                load_count = `CNT_ZERO;
            end
        endcase
    end

    phase_timer #(
        .CNT_W     (`CNT_W)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .load_i    (load),
        .count_i   (load_count),
        .expired_o (expired)
    );

    // Panel reset pulse after master reset release
    logic [`CNT_W-1:0] rst_cnt;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_cnt         <= `CNT_ZERO;
            panel_reset_n_o <= 1'b0;
        end else if (phase == ST_RESET) begin
            rst_cnt <= rst_cnt + `CNT_ONE;
            if (rst_cnt == `CNT_W'(PANEL_RESET_CYC - 1)) begin
                panel_reset_n_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase <= ST_RESET;
        end else begin
            case (phase)
                ST_RESET: if (panel_reset_n_o) phase <= ST_IDLE;
                ST_IDLE:  if (req_valid_i) phase <= ST_SETUP;
                ST_SETUP: if (expired) phase <= ST_LOW;
                ST_LOW:   if (expired) phase <= ST_HIGH;
                ST_HIGH:  if (expired) phase <= ST_DONE;
                ST_DONE:  phase <= ST_IDLE;
                default:  phase <= ST_RESET;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op               <= `OP_RD_INDEX;
            panel_data_bus_o <= `BYTE_ZERO;
        end else if (phase == ST_IDLE && req_valid_i) begin
            op               <= req_op_i;
            panel_data_bus_o <= req_data_i;
        end
    end

    // Pin levels
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            panel_select_n_o       <= 1'b1;
            index_or_data_select_o <= 1'b0;
            store_strobe_n_o       <= 1'b1;
            fetch_strobe_n_o       <= 1'b1;
            panel_data_bus_oe_o    <= 1'b0;
        end else begin
            case (phase)
                ST_IDLE: begin
                    panel_select_n_o <= !req_valid_i;
                    index_or_data_select_o <=
                        req_op_i[`OP_DATA_BIT];
                    panel_data_bus_oe_o <=
                        req_valid_i && req_op_i[`OP_WRITE_BIT];
                end
                ST_SETUP: begin
                    if (expired) begin
                        store_strobe_n_o <= !op[`OP_WRITE_BIT];
                        fetch_strobe_n_o <= op[`OP_WRITE_BIT];
                    end
                end
                ST_LOW: begin
                    if (expired) begin
                        store_strobe_n_o <= 1'b1;
                        fetch_strobe_n_o <= 1'b1;
                    end
                end
                ST_DONE: begin
                    panel_select_n_o    <= 1'b1;
                    panel_data_bus_oe_o <= 1'b0;
                end
                default: begin
                    panel_select_n_o <= panel_select_n_o;
                end
            endcase
        end
    end

    // Two-stage capture of the panel bus pins
    logic [`DATA_W-1:0] bus_meta;
    logic [`DATA_W-1:0] bus_sync;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_meta <= `BYTE_ZERO;
            bus_sync <= `BYTE_ZERO;
        end else begin
            bus_meta <= panel_data_bus_i;
            bus_sync <= bus_meta;
        end
    end

    // Capture as the read strobe rises; bus settled long before
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_data_o  <= `BYTE_ZERO;
            rsp_valid_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            if (phase == ST_LOW && expired && !op[`OP_WRITE_BIT]) begin
                rsp_data_o  <= bus_sync;
                rsp_valid_o <= 1'b1;
            end
        end
    end

    assign req_ready_o = (phase == ST_IDLE);

    // Checks
    logic [`CNT_W-1:0] low_len;
    logic [`CNT_W-1:0] high_len;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_len  <= `CNT_ZERO;
            high_len <= `CNT_ZERO;
        end else begin
            low_len  <= (!store_strobe_n_o || !fetch_strobe_n_o)
                ? low_len + `CNT_ONE : `CNT_ZERO;
            high_len <= (store_strobe_n_o && fetch_strobe_n_o)
                ? high_len + `CNT_ONE : `CNT_ZERO;
        end
    end

    sequence write_low_s;
        !store_strobe_n_o && fetch_strobe_n_o;
    endsequence

    select_gate_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (!store_strobe_n_o || !fetch_strobe_n_o) |-> !panel_select_n_o)
        else $error("strobe active with select high");
    status_read_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !fetch_strobe_n_o && !index_or_data_select_o |-> store_strobe_n_o)
        else $error("status read with write strobe low");
    index_write_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        write_low_s and !index_or_data_select_o |-> !panel_select_n_o)
        else $error("index write bad levels");
    memory_read_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !fetch_strobe_n_o |-> !panel_data_bus_oe_o && store_strobe_n_o)
        else $error("bus driven during read");
    data_write_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        write_low_s |-> panel_data_bus_oe_o && $stable(panel_data_bus_o))
        else $error("write data not driven");
    write_low_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(store_strobe_n_o) |-> low_len >= `CNT_W'(STORE_LOW_CYC))
        else $error("write low too short");
    read_low_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(fetch_strobe_n_o) |-> low_len >= `CNT_W'(FETCH_LOW_CYC))
        else $error("read low too short");
    read_capture_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(fetch_strobe_n_o) |-> rsp_valid_o)
        else $error("read data not captured");
    panel_reset_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !panel_reset_n_o |-> panel_select_n_o && phase == ST_RESET)
        else $error("access during panel reset");

endmodule // panel_bus_master

// ---- sim/panel_model.sv ----
// Behavioural display controller on the far side of the panel bus
`timescale 1ns/10ps
module panel_model (
    input  wire logic       select_n_i,
    input  wire logic       sel_data_i,
    input  wire logic       fetch_n_i,
    input  wire logic       store_n_i,
    input  wire logic       reset_n_i,
    input  wire logic [7:0] bus_i,
    output logic [7:0]      bus_o,
    output logic            bus_oe_o
);
    logic [7:0] index;
    logic [7:0] mem [256];
    // Drives only while selected, reading and out of reset
    assign bus_oe_o = !select_n_i && !fetch_n_i && reset_n_i;
    assign bus_o = sel_data_i ? mem[index] : (index ^ 8'ha5);
    always @(posedge store_n_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            index <= 8'h00;
        end else if (!select_n_i) begin
            if (sel_data_i)
                mem[index] <= bus_i;
            else
                index <= bus_i;
        end
    end
endmodule // panel_model

// ---- sim/display_8080_bus_master_tb.sv ----
// Self-checking bench for the panel bus master with a display model
`timescale 1ns/10ps
`include "panel_bus_params.svh"
module display_8080_bus_master_tb;
    import panel_bus_pkg::*;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       valid = 1'b0;
    op_t        op = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       ready, rsp_v, sel_n, sel_data, rd_n, wr_n, prst_n, oe, m_oe;
    logic [7:0] rsp_d, bus_o, m_bus, bus;
    logic [7:0] last_bus = 8'h00;
    logic [9:0] exp_pin [$];
    logic [7:0] exp_rsp [$];
    int         n_errors = 0;
    int         compares = 0;
    int         cycles = 0;
    int         wl, wh, rl, rh;
    logic       p_wr, p_rd;

    always #2.5 clk = ~clk;

    panel_bus_master #(.PANEL_RESET_NS(100)) DUT (
        .ref_clk_i(clk), .arst_n_i(arst_n), .req_valid_i(valid),
        .req_ready_o(ready), .req_op_i(op), .req_data_i(wdata),
        .rsp_valid_o(rsp_v), .rsp_data_o(rsp_d), .panel_select_n_o(sel_n),
        .index_or_data_select_o(sel_data), .fetch_strobe_n_o(rd_n),
        .store_strobe_n_o(wr_n), .panel_reset_n_o(prst_n),
        .panel_data_bus_i(bus), .panel_data_bus_o(bus_o),
        .panel_data_bus_oe_o(oe));
    panel_model partner (
        .select_n_i(sel_n), .sel_data_i(sel_data), .fetch_n_i(rd_n),
        .store_n_i(wr_n), .reset_n_i(prst_n), .bus_i(bus), .bus_o(m_bus),
        .bus_oe_o(m_oe));

    // Released bus shows the inverse of its last driven value
    assign bus = oe ? bus_o : (m_oe ? m_bus : ~last_bus);
    always @(posedge clk) if (oe || m_oe) last_bus <= bus;

    task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (ready !== 1'b1) n_errors++;
    endtask

    task automatic request(op_t o, logic [7:0] d);
        valid = 1'b1;
        op = o;
        wdata = d;
        wait_ready();
        @(posedge clk);
        #1;
    endtask

    task automatic settle(string name);
        valid = 1'b0;
        wait_ready();
        repeat (3) @(posedge clk);
        check("queues", 10'(exp_pin.size() + exp_rsp.size()), 10'h000);
        $display("test %s done", name);
    endtask

    // Pin watcher: strobe widths, pin levels and written bytes
    always @(posedge clk) begin
        logic [9:0] e;
        cycles++;
        if (cycles > 6000) begin
            n_errors++;
            wrap_up();
        end else if (arst_n !== 1'b1) begin
            wl = 0; rl = 0; wh = 99; rh = 99; p_wr = 1'b1; p_rd = 1'b1;
        end else begin
            if (p_wr === 1'b0 && wr_n === 1'b1) begin
                e = exp_pin.size() ? exp_pin.pop_front() : 10'h3ff;
                check("store low", 10'(wl >= 34), 10'h001);
                check("store pins", {sel_n, rd_n, oe}, 3'b011);
                check("store word", {1'b1, sel_data, bus}, e);
                wl = 0;
            end
            if (p_wr === 1'b1 && wr_n === 1'b0) begin
                check("store high", 10'(wh >= 17), 10'h001);
                check("store select", sel_n, 1'b0);
                wh = 0;
            end
            if (p_rd === 1'b0 && rd_n === 1'b1) begin
                e = exp_pin.size() ? exp_pin.pop_front() : 10'h3ff;
                check("fetch low", 10'(rl >= 60), 10'h001);
                check("fetch pins", {sel_n, wr_n, oe}, 3'b010);
                check("fetch kind", {2'b00, sel_data, 8'h00} , e);
                rl = 0;
            end
            if (p_rd === 1'b1 && rd_n === 1'b0) begin
                check("fetch high", 10'(rh >= 60), 10'h001);
                check("fetch select", sel_n, 1'b0);
                rh = 0;
            end
            if (wr_n === 1'b0) wl++;
            else wh++;
            if (rd_n === 1'b0) rl++;
            else rh++;
            p_wr = wr_n;
            p_rd = rd_n;
        end
    end

    // Reply watcher takes the oldest expected read byte
    always @(posedge clk) begin
        if (arst_n === 1'b1 && rsp_v === 1'b1)
            check("reply", rsp_d, exp_rsp.size() ? exp_rsp.pop_front() : 10'h3ff);
    end

    initial begin
        logic [7:0] idx, d;
        void'($urandom(65));
        repeat (5) @(posedge clk);
        check("reset pins", {sel_n, wr_n, rd_n, oe, prst_n, ready}, 6'b111000);
        #1;
        arst_n = 1'b1;
        repeat (19) @(posedge clk);
        #1;
        check("panel reset held", prst_n, 1'b0);
        wait_ready();
        check("panel reset end", prst_n, 1'b1);
        $display("test panel reset done");
        for (int i = 0; i < 4; i++) begin
            idx = 8'($urandom);
            d = 8'($urandom);
            exp_pin.push_back({2'b10, idx});
            request(`OP_WR_INDEX, idx);
            exp_pin.push_back({2'b11, d});
            request(`OP_WR_DATA, d);
            exp_pin.push_back(10'h000);
            exp_rsp.push_back(idx ^ 8'ha5);
            request(`OP_RD_INDEX, 8'($urandom));
            exp_pin.push_back(10'h100);
            exp_rsp.push_back(d);
            request(`OP_RD_DATA, 8'($urandom));
        end
        settle("all operations");
        exp_pin.push_back({2'b11, 8'h3c});
        request(`OP_WR_DATA, 8'h3c);
        valid = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        arst_n = 1'b0;
        #1;
        check("abort pins", {sel_n, wr_n, rd_n, oe, prst_n, ready}, 6'b111000);
        repeat (5) @(posedge clk);
        exp_pin.delete();
        #1;
        arst_n = 1'b1;
        exp_pin.push_back(10'h000);
        exp_rsp.push_back(8'ha5);
        request(`OP_RD_INDEX, 8'h00);
        settle("reset mid write");
        wrap_up();
    end
endmodule // display_8080_bus_master_tb
